// *** include/pob_defs.svh ***
// Purpose: constants of the peripheral order bus unit controller
// Assumes: 25 MHz clock
// Notes:   offsets are byte addresses on the register bus
`ifndef POB_DEFS_SVH
`define POB_DEFS_SVH

`define POB_CLK_NS        40
`define POB_SYNC_LEAD_NS  400
`define POB_PULSE_NS      500
`define POB_SAMPLE_CYC    ((`POB_SYNC_LEAD_NS + `POB_CLK_NS - 1) / `POB_CLK_NS)
`define POB_REPLY_CYC     (`POB_PULSE_NS / `POB_CLK_NS)

// unit select lines
`define POB_SEL_CODE_LSB  0
`define POB_SEL_CODE_W    12
`define POB_SEL_TYPE_W    5
`define POB_SEL_MEMBER_W  7
`define POB_SEL_MODE      12
`define POB_SEL_SYNC      13

// order write lines
`define POB_ORD_DATA_W    24
`define POB_ORD_OP_LSB    32
`define POB_ORD_W         36
`define POB_ORD_MSYNC     36
`define POB_ORD_SPARE     37
`define POB_ORD_PAR_EVEN  38
`define POB_ORD_PAR_ODD   39

// order opcodes
`define POB_OP_RD_FLAGS   4'h0
`define POB_OP_WR_FLAGS   4'h1
`define POB_OP_RD_BOX     4'h2
`define POB_OP_WR_BOX     4'h3

// poll strobe lines
`define POB_PS_CLOCK      0
`define POB_PS_GROUP      1
`define POB_PS_MEMBER     2
`define POB_PS_HIGH       3
`define POB_PS_IO         7

// answer lines
`define POB_ANS_PARITY    24
`define POB_ANS_ACK       25
`define POB_ANS_FAIL      26
`define POB_ANS_ALARM     27
`define POB_ANS_MINOR     28
`define POB_ANS_USED      32'h1fff_ffff

// registers
`define POB_REG_CTRL      8'h00
`define POB_REG_POLLCFG   8'h04
`define POB_REG_PEND      8'h08
`define POB_REG_MAINT     8'h0c
`define POB_REG_OUTBOX    8'h10
`define POB_REG_INBOX     8'h14
`define POB_REG_STATUS    8'h18
`define POB_ST_INBOX_FULL 0
`define POB_ST_PAR_ERR    1
`define POB_ST_BAD_OP     2

`endif

// *** include/pob_pkg.sv ***
// Purpose: types of the peripheral order bus unit controller
// Assumes: pob_defs.svh constants
// Notes:   bus inputs travel as one struct per bus
package pob_pkg;

  typedef struct packed {
    logic [7:0]  poll;
    logic [39:0] order;
    logic [15:0] sel;
  } pob_bus_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WINDOW, SEQ_EXEC} pob_seq_t;

  typedef struct packed {
    logic replyOne;
    logic replyZero;
    logic listenSel;
    logic svcEntry;
  } pob_flags_t;

  typedef struct packed {
    logic [31:0] word;
    logic        send;
  } pob_drv_state_t;

  typedef struct packed {
    pob_seq_t    seq;
    logic [4:0]  winCnt;
    logic [15:0] selCap;
    logic [39:0] ordCap;
    logic [7:0]  pollPrev;
    logic        maintPrev;
    pob_flags_t  flags;
    logic [14:0] pollCfg;
    logic [4:0]  pending;
    logic [2:0]  trouble;
    logic [19:0] maintData;
    logic [23:0] outbox;
    logic [23:0] inbox;
    logic [2:0]  status;
    logic [31:0] reply;
    logic        sendZero;
    logic        sendOne;
    logic [4:0]  replyCnt;
    logic        wbAck;
    logic [31:0] wbDat;
  } pob_state_t;

endpackage : pob_pkg

// *** design/pob_reply_drv.sv ***
// Purpose: registered driver of one answer bus
// Assumes: open-collector wire resolved outside
// Notes:   unused answer positions are never enabled
`timescale 1ns/1ns
`include "pob_defs.svh"
module pob_reply_drv
  import pob_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        send,
  input  wire logic [31:0] word,
  output logic      [31:0] answerOut,
  output logic      [31:0] answerOe
);
  pob_drv_state_t s_q;
  pob_drv_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.send = send;
    s_d.word = send ? (word & `POB_ANS_USED) : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign answerOut = s_q.word;
  assign answerOe  = s_q.send ? `POB_ANS_USED : 32'h0000_0000;
endmodule : pob_reply_drv

// *** design/pob_unit_ctrl.sv ***
// Purpose: peripheral unit controller end of the duplicated order bus
// Assumes: bus inputs synchronous to clk; host times all pulses
// Notes:   software sees flags, reports and mailboxes over classic Wishbone
`timescale 1ns/1ns
`include "pob_defs.svh"
module pob_unit_ctrl
  import pob_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] wiredCode,
  input  pob_bus_t         busIn0,
  input  pob_bus_t         busIn1,
  input  wire logic        maintPulse,
  output logic      [31:0] answerOut0,
  output logic      [31:0] answerOe0,
  output logic      [31:0] answerOut1,
  output logic      [31:0] answerOe1,
  output logic      [3:0]  unitFlags,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  // sample once the host's address lead behind sync has passed
  localparam logic [4:0] SAMPLE_CYC = 5'(`POB_SAMPLE_CYC);
  // answers stand about one host pulse width
  localparam logic [4:0] REPLY_CYC  = 5'(`POB_REPLY_CYC);

  pob_state_t s_q;
  pob_state_t s_d;

  pob_bus_t    listenBus;
  logic [7:0]  pollRise;
  logic        maintRise;
  logic [47:0] parVec;
  logic        parEven;
  logic        parOdd;
  logic        codeMatch;
  logic        modeOk;
  logic [3:0]  opcode;
  logic [23:0] ordData;
  logic [31:0] regRead;
  logic        wbReq;
  logic        wbWrite;
  logic [31:0] wrMask;
  logic        syncSeen;
  logic        sampleNow;
  logic        parOk;
  logic        ordGo;
  logic        troubleAny;

  // odd parity of a data field
  function automatic logic oddPar24(input logic [23:0] d);
    oddPar24 = ~(^d);
  endfunction : oddPar24

  // byte lanes not selected keep their old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // a report position above the data field would fake parity, ack or trouble bits
  function automatic logic [23:0] dataBit(input logic [4:0] pos);
    dataBit = 24'h00_0000;
    if (pos < 5'(`POB_ANS_PARITY)) begin
      dataBit[pos] = 1'b1;
    end
  endfunction : dataBit

  // receive path follows listen select only
  assign listenBus = s_q.flags.listenSel ? busIn1 : busIn0;
  assign pollRise  = listenBus.poll & ~s_q.pollPrev;
  assign maintRise = maintPulse & ~s_q.maintPrev;
  assign syncSeen  = listenBus.sel[`POB_SEL_SYNC];

  // captured order fields; bits 36 and 37 are never looked at
  assign opcode  = s_q.ordCap[`POB_ORD_OP_LSB +: 4];
  assign ordData = s_q.ordCap[`POB_ORD_DATA_W-1:0];
  assign parVec  = {s_q.ordCap[`POB_ORD_W-1:0], s_q.selCap[`POB_SEL_CODE_W-1:0]};

  always_comb begin
    parEven = s_q.ordCap[`POB_ORD_PAR_EVEN];
    parOdd  = s_q.ordCap[`POB_ORD_PAR_ODD];
    for (int i = 0; i < 48; i += 2) begin
      parEven = parEven ^ parVec[i];
      parOdd  = parOdd ^ parVec[i+1];
    end
  end

  // type and member together form the wired code
  assign codeMatch = s_q.selCap[`POB_SEL_CODE_W-1:0] == wiredCode;
  // maintenance class orders reach only a unit with service entry set
  assign modeOk    = ~s_q.selCap[`POB_SEL_MODE] | s_q.flags.svcEntry;
  assign parOk     = parEven & parOdd;
  assign sampleNow = s_q.winCnt == SAMPLE_CYC;
  // winCnt is cleared on execution, so a long sync never runs an order twice
  assign ordGo     = s_q.winCnt != 5'h00 && codeMatch && modeOk;
  // interrogates answer only while something is wrong
  assign troubleAny = |s_q.trouble;

  assign wbReq   = wb_cyc_i & wb_stb_i & ~s_q.wbAck;
  // a write lands at the acknowledged edge, while the master still holds it
  assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & s_q.wbAck;
  assign wrMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    unique case (wb_adr_i)
      `POB_REG_CTRL:    regRead = {28'h0, s_q.flags};
      `POB_REG_POLLCFG: regRead = {17'h0, s_q.pollCfg};
      `POB_REG_PEND:    regRead = {21'h0, s_q.trouble, 3'h0, s_q.pending};
      `POB_REG_MAINT:   regRead = {12'h0, s_q.maintData};
      `POB_REG_OUTBOX:  regRead = {8'h0, s_q.outbox};
      `POB_REG_INBOX:   regRead = {8'h0, s_q.inbox};
      `POB_REG_STATUS:  regRead = {29'h0, s_q.status};
      default:          regRead = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic [31:0] w;
    logic [31:0] pollWord;
    logic        intgHit;
    logic        pollHit;
    pob_flags_t  nf;
    w        = 32'h0000_0000;
    pollWord = 32'h0000_0000;
    intgHit  = 1'b0;
    pollHit  = 1'b0;
    nf       = s_q.flags;
    s_d      = s_q;

    // register bus: one wait state, unmapped reads zero
    s_d.wbAck = wbReq;
    s_d.wbDat = wbReq ? regRead : 32'h0000_0000;
    if (wbWrite) begin
      unique case (wb_adr_i)
        `POB_REG_CTRL: begin
          s_d.flags = pob_flags_t'(4'(merge({28'h0, s_q.flags}, wb_dat_i, wrMask)));
        end
        `POB_REG_POLLCFG: begin
          s_d.pollCfg = 15'(merge({17'h0, s_q.pollCfg}, wb_dat_i, wrMask));
        end
        `POB_REG_PEND: begin
          s_d.pending = wrMask[0] ? wb_dat_i[4:0] : s_q.pending;
          s_d.trouble = wrMask[8] ? wb_dat_i[10:8] : s_q.trouble;
        end
        `POB_REG_MAINT: begin
          s_d.maintData = 20'(merge({12'h0, s_q.maintData}, wb_dat_i, wrMask));
        end
        `POB_REG_OUTBOX: begin
          s_d.outbox = 24'(merge({8'h0, s_q.outbox}, wb_dat_i, wrMask));
        end
        `POB_REG_STATUS: begin
          // write one to clear
          if (wrMask[0]) begin
            s_d.status = s_q.status & ~wb_dat_i[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // answer hold timer
    if (s_q.replyCnt != 5'h00) begin
      s_d.replyCnt = s_q.replyCnt - 5'h01;
    end else begin
      s_d.sendZero = 1'b0;
      s_d.sendOne  = 1'b0;
      s_d.reply    = 32'h0000_0000;
    end

    // order capture: sample a fixed time after the sync pulse
    unique case (s_q.seq)
      // wait for the sync pulse
      SEQ_IDLE: begin
        if (syncSeen) begin
          s_d.seq    = SEQ_WINDOW;
          s_d.winCnt = 5'h01;
        end
      end
      // window open: the lines are registered at the sample point
      SEQ_WINDOW: begin
        s_d.winCnt = s_q.winCnt + 5'h01;
        if (sampleNow) begin
          s_d.seq    = SEQ_EXEC;
          s_d.selCap = listenBus.sel;
          s_d.ordCap = listenBus.order;
        end
      end
      // execute once, then wait for sync to fall
      SEQ_EXEC: begin
        s_d.winCnt = 5'h00;
        if (!syncSeen) begin
          s_d.seq = SEQ_IDLE;
        end
        if (ordGo) begin
          if (!parOk) begin
            s_d.status[`POB_ST_PAR_ERR] = 1'b1;
          end else begin
            w[`POB_ANS_ACK] = 1'b1;
            unique case (opcode)
              `POB_OP_RD_FLAGS: w[3:0] = s_q.flags;
              `POB_OP_WR_FLAGS: s_d.flags = pob_flags_t'(ordData[3:0]);
              `POB_OP_RD_BOX:   w[23:0] = s_q.outbox;
              `POB_OP_WR_BOX: begin
                s_d.inbox = ordData;
                s_d.status[`POB_ST_INBOX_FULL] = 1'b1;
              end
              default: begin
                // unknown order is not executed, so no acknowledge
                w[`POB_ANS_ACK] = 1'b0;
                s_d.status[`POB_ST_BAD_OP] = 1'b1;
              end
            endcase
            if (w[`POB_ANS_ACK]) begin
              w[`POB_ANS_PARITY] = oddPar24(w[23:0]);
              s_d.reply    = w;
              s_d.sendZero = s_q.flags.replyZero;
              s_d.sendOne  = s_q.flags.replyOne;
              s_d.replyCnt = REPLY_CYC;
            end
          end
        end
      end
      // the fourth code of the state field is unused
      default: begin
        s_d.seq = SEQ_IDLE;
      end
    endcase

    // poll and interrogate answers
    if (!s_q.flags.svcEntry) begin
      if (pollRise[`POB_PS_CLOCK] && troubleAny) begin
        intgHit = 1'b1;
        // failure, alarm, minor alarm by falling urgency
        pollWord[`POB_ANS_MINOR:`POB_ANS_FAIL] = s_q.trouble;
      end
      if (pollRise[`POB_PS_GROUP] && troubleAny) begin
        intgHit = 1'b1;
        pollWord[23:0] = pollWord[23:0] | dataBit(s_q.pollCfg[9:5]);
      end
      if (pollRise[`POB_PS_MEMBER] && troubleAny) begin
        intgHit = 1'b1;
        pollWord[23:0] = pollWord[23:0] | dataBit(s_q.pollCfg[14:10]);
      end
      for (int k = 0; k < 5; k++) begin
        if (pollRise[`POB_PS_HIGH + k] && s_q.pending[k]) begin
          pollHit = 1'b1;
          pollWord[23:0] = pollWord[23:0] | dataBit(s_q.pollCfg[4:0]);
        end
      end
      if (intgHit || pollHit) begin
        pollWord[`POB_ANS_PARITY] = oddPar24(pollWord[23:0]);
        s_d.reply    = pollWord;
        // interrogates on both buses, polls by reply paths
        s_d.sendZero = intgHit | (pollHit & s_q.flags.replyZero);
        s_d.sendOne  = intgHit | (pollHit & s_q.flags.replyOne);
        s_d.replyCnt = REPLY_CYC;
      end
    end

    // maintenance access pulse: toggle listen, report on the new bus
    if (maintRise) begin
      nf.listenSel  = ~s_q.flags.listenSel;
      s_d.flags     = nf;
      w             = {8'h0, s_q.maintData, nf};
      w[`POB_ANS_PARITY] = oddPar24(w[23:0]);
      s_d.reply     = w;
      s_d.sendZero  = ~nf.listenSel;
      s_d.sendOne   = nf.listenSel;
      s_d.replyCnt  = REPLY_CYC;
    end

    s_d.pollPrev  = listenBus.poll;
    s_d.maintPrev = maintPulse;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q     <= '0;
      s_q.seq <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // bits 29 to 31 are masked off inside each driver
  pob_reply_drv u_drv0 (
    .clk       (clk),
    .rstn      (rstn),
    .send      (s_q.sendZero),
    .word      (s_q.reply),
    .answerOut (answerOut0),
    .answerOe  (answerOe0)
  );

  pob_reply_drv u_drv1 (
    .clk       (clk),
    .rstn      (rstn),
    .send      (s_q.sendOne),
    .word      (s_q.reply),
    .answerOut (answerOut1),
    .answerOe  (answerOe1)
  );

  assign unitFlags = s_q.flags;
  assign wb_dat_o  = s_q.wbDat;
  assign wb_ack_o  = s_q.wbAck;
endmodule : pob_unit_ctrl

// *** sim/pob_host_model.sv ***
// Purpose: host end of the duplicated order bus
// Assumes: orders and poll pulses go out on both buses, maintenance pulses on their own line
// Notes:   released order lines show the inverse of their last value
`timescale 1ns/1ns
module pob_host_model
  import pob_pkg::*;
(
  input  wire logic clk,
  output pob_bus_t  bus0,
  output pob_bus_t  bus1,
  output logic      maintPulse
);
  pob_bus_t bus;

  // sole sender, as the active control with dual send or override; no standby
  // control ever transmits; poll pulses on both buses whatever the routing
  assign bus0 = bus;
  assign bus1 = bus;

  initial begin
    bus = '0;
    maintPulse = 1'b0;
  end

  // each interleaved group odd, returned as {odd, even}
  function automatic logic [1:0] par_of(input logic [47:0] v);
    logic [1:0] p;
    p = 2'b11;
    for (int i = 0; i < 48; i++) p[i % 2] ^= v[i];
    return p;
  endfunction : par_of

  task automatic send_order(input logic [11:0] c, input logic m, input logic [3:0] op,
                            input logic [23:0] d, input logic bad);
    logic [39:0] o;
    o = {4'h3, op, 8'h00, d};  // bits 36 and 37 set, receivers must ignore them
    o[39:38] = par_of({o[35:0], c}) ^ {1'b0, bad};
    @(posedge clk);
    bus.sel[13] <= 1'b1;
    repeat (6) @(posedge clk);
    bus.sel[12:0] <= {m, c};
    bus.order <= o;
    repeat (6) @(posedge clk);
    bus.sel[13] <= 1'b0;
    repeat (6) @(posedge clk);
    bus.sel[12:0] <= ~{m, c};
    bus.order <= ~o;
  endtask : send_order

  // 8 means maintenance access; one line at a time
  task automatic pulse(input int i);
    @(posedge clk);
    if (i < 8) bus.poll[i] <= 1'b1;
    else maintPulse <= 1'b1;
    repeat (12) @(posedge clk);
    bus.poll <= 8'h00;
    maintPulse <= 1'b0;
  endtask : pulse
endmodule : pob_host_model

// *** sim/pob_unit_ctrl_sva.sv ***
// Purpose: port checks of the unit controller
// Assumes: bound into pob_unit_ctrl
// Notes:   one clock domain, so default clocking
`timescale 1ns/1ns
module pob_unit_ctrl_sva
  import pob_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input pob_bus_t         busIn0,
  input wire logic        maintPulse,
  input wire logic [31:0] answerOut0,
  input wire logic [31:0] answerOe0,
  input wire logic [31:0] answerOut1,
  input wire logic [31:0] answerOe1,
  input wire logic [3:0]  unitFlags,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_mrise;
    $rose(maintPulse);
  endsequence
  // high poll seen on listen bus 0 with bus 1 quiet
  sequence s_hi_idle;
    $rose(busIn0.poll[3]) && answerOe1 == 32'h0 && !unitFlags[1];
  endsequence

  property p_oe_shape;
    answerOe0 inside {32'h0, 32'h1fff_ffff} && answerOe1 inside {32'h0, 32'h1fff_ffff};
  endproperty
  a_oe_shape: assert property (p_oe_shape) else $error("bad enable shape");
  property p_par;
    answerOe0 != 32'h0 && answerOut0[25] |-> answerOut0[24] == ~^answerOut0[23:0];
  endproperty
  a_par: assert property (p_par) else $error("answer parity wrong");
  property p_wb_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_wb_take: assert property (p_wb_take) else $error("bus request unanswered");
  property p_wb_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("ack longer than a cycle");
  property p_m_toggle;
    s_mrise |=> unitFlags[1] != $past(unitFlags[1]);
  endproperty
  a_m_toggle: assert property (p_m_toggle) else $error("listen not toggled");
  property p_m_ans;
    s_mrise |-> ##[1:5] ((unitFlags[1] ? answerOe1 : answerOe0) != 32'h0);
  endproperty
  a_m_ans: assert property (p_m_ans) else $error("no maintenance answer");
  // interrogate answers mirror on both buses
  property p_intg;
    $rose(busIn0.poll[1]) && !unitFlags[1] |-> ##1 (answerOe0 == answerOe1)[*4];
  endproperty
  a_intg: assert property (p_intg) else $error("interrogate on one bus");
  property p_path;
    s_hi_idle ##0 unitFlags == 4'h4 |-> ##1 (answerOe1 == 32'h0)[*4];
  endproperty
  a_path: assert property (p_path) else $error("poll on unselected path");
  property p_quiet;
    s_hi_idle ##0 unitFlags == 4'h5 && answerOe0 == 32'h0 |-> ##1 (answerOe0 == 32'h0)[*4];
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer in service entry");
endmodule : pob_unit_ctrl_sva

bind pob_unit_ctrl pob_unit_ctrl_sva u_sva (.clk, .rstn, .busIn0, .maintPulse, .answerOut0,
  .answerOe0, .answerOut1, .answerOe1, .unitFlags, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// *** sim/pob_unit_ctrl_bench.sv ***
// Purpose: self-checking bench of the unit controller
// Assumes: host model drives both buses alike
// Notes:   answers judged at the falling edge, inside their hold
`timescale 1ns/1ns
`include "pob_defs.svh"
module pob_unit_ctrl_bench
  import pob_pkg::*;
;
  logic        clk, rstn, maintPulse, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, unitFlags;
  logic [31:0] wb_dat_i, wb_dat_o, answerOut0, answerOe0, answerOut1, answerOe1, q;
  logic [11:0] wiredCode;
  pob_bus_t    bus0, bus1;
  int          miscompares = 0;
  int          nTests = 0;

  pob_host_model host (.clk, .bus0, .bus1, .maintPulse);
  pob_unit_ctrl dut (.clk, .rstn, .wiredCode, .busIn0(bus0), .busIn1(bus1), .maintPulse,
    .answerOut0, .answerOe0, .answerOut1, .answerOe1, .unitFlags, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // waits for ack without assuming its latency
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 20);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20) miscompares++;
  endtask : wb_xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd_chk

  // cop is {class, opcode}; answer bits 25 to 0 on bus 0 compared whenever acknowledged
  task automatic order(input logic [11:0] c, input logic [4:0] cop, input logic [23:0] d,
                       input logic bad, input logic [25:0] ans);
    host.send_order(c, cop[4], cop[3:0], d, bad);
    @(negedge clk);
    // judged some 19 cycles after the start, while the answer is still held
    check(answerOe0, ans[25] ? 32'h1fff_ffff : 32'h0);
    check(answerOe1, 32'h0);
    if (ans[25]) check(answerOut0[25:0], ans);
    repeat (10) @(posedge clk);
  endtask : order

  task automatic t_orders;
    wb_xfer(1'b1, `POB_REG_CTRL, 32'h4, q);
    rd_chk(`POB_REG_CTRL, 32'h4);
    rd_chk(8'h1c, 32'h0);
    wb_xfer(1'b1, `POB_REG_OUTBOX, 32'h3c_a596, q);
    order(wiredCode, 5'h1, 24'h6, 1'b0, 26'h300_0000);
    check(unitFlags, 32'h6);
    order(wiredCode, 5'h2, 24'h0, 1'b0, {1'b1, ~^24'h3c_a596, 24'h3c_a596});
    order(wiredCode ^ 12'h080, 5'h2, 24'h0, 1'b0, 26'h0);
    order(wiredCode, 5'h12, 24'h0, 1'b0, 26'h0);
    order(wiredCode, 5'h2, 24'h0, 1'b1, 26'h0);
    rd_chk(`POB_REG_STATUS, 32'h2);
    order(wiredCode, 5'h3, 24'h12_3456, 1'b0, 26'h300_0000);
    rd_chk(`POB_REG_INBOX, 32'h12_3456);
  endtask : t_orders

  task automatic t_polls;
    wb_xfer(1'b1, `POB_REG_CTRL, 32'h4, q);
    wb_xfer(1'b1, `POB_REG_POLLCFG, 32'h4525, q);
    for (int k = 0; k < 5; k++) begin
      wb_xfer(1'b1, `POB_REG_PEND, 32'h700 | (32'h1 << k), q);
      host.pulse(3 + k);
      @(negedge clk);
      check(answerOut0[23:0], 32'h20);
      check(answerOe1, 32'h0);
    end
    host.pulse(0);
    @(negedge clk);
    check({answerOut0[28:26], answerOut1[28:26]}, 32'h3f);
    host.pulse(1);
    @(negedge clk);
    check(answerOut1[23:0], 32'h200);
    host.pulse(2);
    @(negedge clk);
    check(answerOut0[23:0], 32'h2_0000);
  endtask : t_polls

  task automatic t_maint;
    wb_xfer(1'b1, `POB_REG_MAINT, 32'hab_cde, q);
    wb_xfer(1'b1, `POB_REG_CTRL, 32'h5, q);
    // a high report is pending, so only service entry keeps the answer back
    wb_xfer(1'b1, `POB_REG_PEND, 32'h701, q);
    host.pulse(3);
    @(negedge clk);
    check(answerOe0 | answerOe1, 32'h0);
    host.pulse(8);
    @(negedge clk);
    check(unitFlags, 32'h7);
    check(answerOe1, 32'h1fff_ffff);
    check(answerOut1[23:0], 32'hab_cde7);
    repeat (10) @(posedge clk);
    order(wiredCode, 5'h10, 24'h0, 1'b0, {1'b1, 1'b0, 24'h7});
  endtask : t_maint

  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    wiredCode = 12'h5a3;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(answerOe0 | answerOe1 | unitFlags, 32'h0);
    t_orders();
    t_polls();
    t_maint();
    tally_and_finish();
  end

  // a hang costs a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : pob_unit_ctrl_bench
